// ==== dbc_break_ctrl.sv ====
// Overview of operation
// - writing break-next zero releases a held CPU
// - break-next one halts at next instruction
// - breaks taken only at first opcode byte
// - clock high, data low at reset sets break-next
// - address-match break sets break-next automatically
// - host writing one forces a break
// - four enable bits gate address matches
// - match 1 compares all 24 bits normally
// - ignore-low-byte makes match 1 page-wide
module dbc_break_ctrl
    import dbc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  hsel,
    input  wire logic [HADDR_W-1:0]    haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [HDATA_W-1:0]    hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [HDATA_W-1:0]    hrdata,
    input  wire logic                  debugClockPin,
    input  wire logic                  debugDataPin,
    input  wire logic                  cpuFetchValid,
    input  wire logic                  cpuFetchFirst,
    input  wire logic [CPU_ADDR_W-1:0] cpuFetchAddr,
    output logic                       cpuHalt,
    output logic                       breakIrq
);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BUS_IDLE   = 4'b0001,
        BUS_WRITE  = 4'b0010,
        BUS_RDWAIT = 4'b0100,
        BUS_RDDATA = 4'b1000
    } dbcBusState_t;

    typedef enum logic [1:0] {
        CPU_RUN    = 2'b01,
        CPU_HALTED = 2'b10
    } dbcCpuState_t;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    dbcBusState_t               busState_q;
    dbcBusState_t               busState_d;
    dbcCpuState_t               cpuState_q;
    dbcCpuState_t               cpuState_d;
    logic [OFFSET_W-1:0]        busOfs_q;
    logic                       busWord_q;
    logic                       addrAccept;
    logic                       wrStrobe;
    logic [HDATA_W-1:0]         rdWord;
    logic [HDATA_W-1:0]         hrdata_q;
    logic                       brkNext_q;
    logic                       brkNext_d;
    logic [MATCH_COUNT-1:0]     brkEn_q;
    logic                       ignLow_q;
    logic [CPU_ADDR_W-1:0]      matchAddr_q [MATCH_COUNT];
    logic [MATCH_COUNT-1:0]     matchHit;
    logic                       anyHit;
    logic                       fetchBoundary;
    logic                       breakTake;
    logic                       matchBreak;
    logic [1:0]                 pinSync;
    logic                       clkPinPrev_q;
    logic                       linkEdge;
    logic                       strapDone_q;
    logic                       strapHit;
    logic                       strapSeen_q;
    logic [IRQ_W-1:0]           irqStat_q;
    logic [IRQ_W-1:0]           irqMask_q;
    logic [IRQ_W-1:0]           irqEvent;
    logic [7:0]                 ctrlByte;
    logic [7:0]                 statusByte;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic regHit(
        input logic [OFFSET_W-1:0] ofs,
        input logic [7:0]          target
    );
        regHit = (ofs == target);
    endfunction : regHit

    function automatic logic [CPU_ADDR_W-1:0] matchOfsIdx(
        input logic [OFFSET_W-1:0] ofs,
        input int unsigned         idx
    );
        logic [7:0] base;
        base = OFS_MATCH0 + 8'(idx * 4);
        matchOfsIdx = {CPU_ADDR_W{ofs == base}};
    endfunction : matchOfsIdx

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    dbc_sync #(
        .WIDTH (2)
    ) uPinSync (
        .clk_sys (clk_sys),
        .asyncIn ({debugDataPin, debugClockPin}),
        .syncOut (pinSync)
    );

    // ------------------------------------------------------------
    // link clock edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            clkPinPrev_q <= 1'b1;
        end
        else
        begin
            clkPinPrev_q <= pinSync[0];
        end
    end

    assign linkEdge = pinSync[0] && !clkPinPrev_q;

    // ------------------------------------------------------------
    // strap capture at reset release
    // ------------------------------------------------------------
    assign strapHit = !strapDone_q && pinSync[0] && !pinSync[1];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            strapDone_q <= 1'b0;
            strapSeen_q <= 1'b0;
        end
        else
        begin
            strapDone_q <= 1'b1;
            if (strapHit)
            begin
                strapSeen_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    assign addrAccept = hsel && hready && htrans[1];
    assign hreadyout  = (busState_q != BUS_RDWAIT);
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_q;
    assign wrStrobe   = (busState_q == BUS_WRITE) && busWord_q;

    always_comb
    begin
        busState_d = busState_q;
        unique case (busState_q)
            BUS_RDWAIT:
            begin
                busState_d = BUS_RDDATA;
            end
            BUS_IDLE, BUS_WRITE, BUS_RDDATA:
            begin
                if (addrAccept)
                begin
                    busState_d = hwrite ? BUS_WRITE : BUS_RDWAIT;
                end
                else
                begin
                    busState_d = BUS_IDLE;
                end
            end
            default:
            begin
                busState_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            busState_q <= BUS_IDLE;
            busOfs_q   <= 8'h00;
            busWord_q  <= 1'b0;
        end
        else
        begin
            busState_q <= busState_d;
            if (addrAccept)
            begin
                busOfs_q  <= haddr[OFFSET_W-1:0];
                busWord_q <= (hsize == 3'h2) && (haddr[HADDR_W-1:OFFSET_W] == 24'h000000);
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    assign ctrlByte   = {brkNext_q, brkEn_q, ignLow_q, 2'h0};
    assign statusByte = {4'h0, strapSeen_q, pinSync[1], pinSync[0], (cpuState_q == CPU_HALTED)};

    always_comb
    begin
        rdWord = 32'h00000000;
        if (busWord_q)
        begin
            if (regHit(busOfs_q, OFS_CTRL))
            begin
                rdWord = {24'h000000, ctrlByte};
            end
            if (regHit(busOfs_q, OFS_STATUS))
            begin
                rdWord = {24'h000000, statusByte};
            end
            if (regHit(busOfs_q, OFS_IRQ_STAT))
            begin
                rdWord = {29'h00000000, irqStat_q};
            end
            if (regHit(busOfs_q, OFS_IRQ_MASK))
            begin
                rdWord = {29'h00000000, irqMask_q};
            end
            for (int i = 0; i < MATCH_COUNT; i++)
            begin
                rdWord[CPU_ADDR_W-1:0] = rdWord[CPU_ADDR_W-1:0] | (matchAddr_q[i] & matchOfsIdx(busOfs_q, i));
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            hrdata_q <= 32'h00000000;
        end
        else if (busState_q == BUS_RDWAIT)
        begin
            hrdata_q <= rdWord;
        end
    end

    // ------------------------------------------------------------
    // match address registers and comparators
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < MATCH_COUNT; g++)
        begin : gMatch
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    matchAddr_q[g] <= MATCH_RST;
                end
                else if (wrStrobe && (matchOfsIdx(busOfs_q, g) != 24'h000000))
                begin
                    matchAddr_q[g] <= hwdata[CPU_ADDR_W-1:0];
                end
            end

            dbc_match #(
                .PAGE_CAPABLE (g == IGN_LOW_IDX)
            ) uMatch (
                .fetchAddr (cpuFetchAddr),
                .matchAddr (matchAddr_q[g]),
                .matchEn   (brkEn_q[g]),
                .ignoreLow (ignLow_q),
                .hit       (matchHit[g])
            );
        end
    endgenerate

    assign anyHit = |matchHit;

    // ------------------------------------------------------------
    // break decision
    // ------------------------------------------------------------
    assign fetchBoundary = cpuFetchValid && cpuFetchFirst;
    assign breakTake     = fetchBoundary && (cpuState_q == CPU_RUN) && (brkNext_q || anyHit);
    assign matchBreak    = breakTake && anyHit;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb
    begin
        brkNext_d = brkNext_q;
        if (wrStrobe && regHit(busOfs_q, OFS_CTRL))
        begin
            brkNext_d = hwdata[BRK_NEXT_BIT];
        end
        if (matchBreak)
        begin
            brkNext_d = 1'b1;
        end
        if (strapHit)
        begin
            brkNext_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            brkNext_q <= CTRL_RST[BRK_NEXT_BIT];
            brkEn_q   <= CTRL_RST[BRK_EN_MSB:BRK_EN_LSB];
            ignLow_q  <= CTRL_RST[IGN_LOW_BIT];
        end
        else
        begin
            brkNext_q <= brkNext_d;
            if (wrStrobe && regHit(busOfs_q, OFS_CTRL))
            begin
                brkEn_q  <= hwdata[BRK_EN_MSB:BRK_EN_LSB];
                ignLow_q <= hwdata[IGN_LOW_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // cpu halt state
    // ------------------------------------------------------------
    always_comb
    begin
        cpuState_d = cpuState_q;
        unique case (cpuState_q)
            CPU_RUN:
            begin
                if (breakTake)
                begin
                    cpuState_d = CPU_HALTED;
                end
            end
            CPU_HALTED:
            begin
                if (!brkNext_q)
                begin
                    cpuState_d = CPU_RUN;
                end
            end
            default:
            begin
                cpuState_d = CPU_HALTED;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cpuState_q <= CPU_RUN;
        end
        else
        begin
            cpuState_q <= cpuState_d;
        end
    end

    // stall the fetch in the break cycle and while held
    assign cpuHalt = (cpuState_q == CPU_HALTED) || breakTake;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        irqEvent            = IRQ_RST;
        irqEvent[IRQ_BREAK] = breakTake;
        irqEvent[IRQ_MATCH] = matchBreak;
        irqEvent[IRQ_LINK]  = linkEdge;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            irqStat_q <= IRQ_RST;
            irqMask_q <= IRQ_RST;
        end
        else
        begin
            if (wrStrobe && regHit(busOfs_q, OFS_IRQ_STAT))
            begin
                irqStat_q <= (irqStat_q & ~hwdata[IRQ_W-1:0]) | irqEvent;
            end
            else
            begin
                irqStat_q <= irqStat_q | irqEvent;
            end
            if (wrStrobe && regHit(busOfs_q, OFS_IRQ_MASK))
            begin
                irqMask_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    assign breakIrq = |(irqStat_q & irqMask_q);

endmodule : dbc_break_ctrl

// ==== dbc_pkg.sv ====
package dbc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned HADDR_W      = 32;
    localparam int unsigned HDATA_W      = 32;
    localparam int unsigned OFFSET_W     = 8;
    localparam int unsigned CPU_ADDR_W   = 24;
    localparam int unsigned MATCH_COUNT  = 4;
    localparam int unsigned IRQ_W        = 3;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_MATCH0    = 8'h04;
    localparam logic [7:0] OFS_MATCH1    = 8'h08;
    localparam logic [7:0] OFS_MATCH2    = 8'h0C;
    localparam logic [7:0] OFS_MATCH3    = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned BRK_NEXT_BIT = 7;
    localparam int unsigned BRK_EN_MSB   = 6;
    localparam int unsigned BRK_EN_LSB   = 3;
    localparam int unsigned IGN_LOW_BIT  = 2;
    localparam int unsigned IGN_LOW_IDX  = 1;
    localparam int unsigned PAGE_LSB     = 8;

    // ------------------------------------------------------------
    // status and interrupt fields
    // ------------------------------------------------------------
    localparam int unsigned STS_HALTED   = 0;
    localparam int unsigned STS_CLK_PIN  = 1;
    localparam int unsigned STS_DATA_PIN = 2;
    localparam int unsigned STS_STRAP    = 3;
    localparam int unsigned IRQ_BREAK    = 0;
    localparam int unsigned IRQ_MATCH    = 1;
    localparam int unsigned IRQ_LINK     = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]            CTRL_RST  = 8'h00;
    localparam logic [CPU_ADDR_W-1:0] MATCH_RST = 24'h000000;
    localparam logic [IRQ_W-1:0]      IRQ_RST   = 3'h0;

endpackage : dbc_pkg

// ==== dbc_sync.sv ====
module dbc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    // ------------------------------------------------------------
    // two-stage synchroniser, unreset so pin levels reach strap logic
    // ------------------------------------------------------------
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clk_sys)
    begin
        stage1_q <= asyncIn;
        stage2_q <= stage1_q;
    end

    assign syncOut = stage2_q;

endmodule : dbc_sync

// ==== dbc_match.sv ====
module dbc_match
    import dbc_pkg::*;
#(
    parameter bit PAGE_CAPABLE = 1'b0
) (
    input  wire logic [CPU_ADDR_W-1:0] fetchAddr,
    input  wire logic [CPU_ADDR_W-1:0] matchAddr,
    input  wire logic                  matchEn,
    input  wire logic                  ignoreLow,
    output logic                       hit
);

    // ------------------------------------------------------------
    // address comparator
    // ------------------------------------------------------------
    logic upperEq;
    logic lowerEq;
    logic lowerSkip;

    assign upperEq   = (fetchAddr[CPU_ADDR_W-1:PAGE_LSB] == matchAddr[CPU_ADDR_W-1:PAGE_LSB]);
    assign lowerEq   = (fetchAddr[PAGE_LSB-1:0] == matchAddr[PAGE_LSB-1:0]);
    assign lowerSkip = PAGE_CAPABLE && ignoreLow;

    // full compare unless page mode
    assign hit = matchEn && upperEq && (lowerEq || lowerSkip);

endmodule : dbc_match

// ==== dbc_break_ctrl_sva.sv ====
module dbc_break_ctrl_sva
    import dbc_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst_b,
    input wire logic                  hsel,
    input wire logic [HADDR_W-1:0]    haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [HDATA_W-1:0]    hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic                  debugClockPin,
    input wire logic                  debugDataPin,
    input wire logic                  cpuFetchValid,
    input wire logic                  cpuFetchFirst,
    input wire logic                  cpuHalt,
    input wire logic                  breakIrq
);
    // ------------------------------------------------------------
    // write data-phase tracking
    // ------------------------------------------------------------
    logic wrCtrl_q;
    logic wrMask_q;
    logic takenW;
    logic relZero;
    logic relAll;
    logic mskZero;

    assign takenW  = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
    assign relZero = wrCtrl_q && !hwdata[BRK_NEXT_BIT];
    assign relAll  = relZero && hwdata[BRK_EN_MSB:BRK_EN_LSB] == 4'h0;
    assign mskZero = wrMask_q && hwdata[IRQ_W-1:0] == 3'h0;

    always_ff @(posedge clk_sys)
        wrCtrl_q <= rst_b && takenW && haddr == {24'h000000, OFS_CTRL};

    always_ff @(posedge clk_sys)
        wrMask_q <= rst_b && takenW && haddr == {24'h000000, OFS_IRQ_MASK};

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_rd_taken;
        hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
    endsequence
    sequence s_set_then_fetch;
        wrCtrl_q && hwdata[BRK_NEXT_BIT] ##1 cpuFetchValid && cpuFetchFirst;
    endsequence
    sequence s_strap_fetch;
        $rose(rst_b) && debugClockPin && !debugDataPin ##[1:8] cpuFetchValid && cpuFetchFirst;
    endsequence

    a_halt_first_byte: assert property ($rose(cpuHalt) |-> cpuFetchValid && cpuFetchFirst)
        else $error("halt raised without a first opcode fetch");
    a_halt_held: assert property ($fell(cpuHalt) |-> $past(relZero, 2))
        else $error("halt dropped without a release write");
    a_release_time: assert property (relAll |-> ##2 !cpuHalt)
        else $error("cpu not released two cycles after clear");
    a_force_next: assert property (s_set_then_fetch |-> cpuHalt)
        else $error("break-next set but fetch not halted");
    a_strap_halt: assert property (s_strap_fetch |-> cpuHalt)
        else $error("strap levels did not halt first fetch");
    a_read_wait: assert property (s_rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (takenW |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response given");
    a_irq_masked: assert property (mskZero |=> !breakIrq)
        else $error("interrupt high with zero mask");
endmodule : dbc_break_ctrl_sva

bind dbc_break_ctrl dbc_break_ctrl_sva u_sva (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .debugClockPin, .debugDataPin, .cpuFetchValid, .cpuFetchFirst, .cpuHalt, .breakIrq);

// ==== dbc_debug_host.sv ====
module dbc_debug_host
(
    output logic debugClockPin,
    output logic debugDataPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // strap and link frames
    // ------------------------------------------------------------
    initial
    begin
        debugClockPin = 1'b1;
        debugDataPin  = 1'b0;
    end

    // data released to its pull-up level
    task automatic release_strap();
        debugDataPin <= 1'b1;
    endtask : release_strap

    // clock idles high, runs only inside a frame
    task automatic frame(input logic [7:0] bits);
        for (int i = 7; i >= 0; i--)
        begin
            debugDataPin <= bits[i];
            #160 debugClockPin <= 1'b0;
            #160 debugClockPin <= 1'b1;
        end
        debugDataPin <= 1'b1;
    endtask : frame
endmodule : dbc_debug_host

// ==== dbc_break_ctrl_tb.sv ====
module dbc_break_ctrl_tb
    import dbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk_sys;
    logic                  rst_b;
    logic                  hsel;
    logic [HADDR_W-1:0]    haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [HDATA_W-1:0]    hwdata;
    logic                  hreadyout;
    logic                  hresp;
    logic [HDATA_W-1:0]    hrdata;
    logic                  debugClockPin;
    logic                  debugDataPin;
    logic                  cpuFetchValid;
    logic                  cpuFetchFirst;
    logic [CPU_ADDR_W-1:0] cpuFetchAddr;
    logic                  cpuHalt;
    logic                  breakIrq;
    int                    nErrors;
    int                    nCompared;

    dbc_break_ctrl u_dut (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .debugClockPin, .debugDataPin, .cpuFetchValid, .cpuFetchFirst, .cpuFetchAddr,
        .cpuHalt, .breakIrq);
    dbc_debug_host u_host (.debugClockPin, .debugDataPin);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nCompared++;
        if (got !== exp)
        begin
            nErrors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
        haddr  <= {24'h000000, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        hsel   <= 1'b1;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ofs, d, x);
    endtask : wr

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] e, input string m);
        logic [31:0] x;
        bus(1'b0, ofs, 32'h00000000, x);
        check(x, e, m);
    endtask : rdchk

    task automatic fetch(input logic [23:0] a, input logic f, input logic e, input string m);
        cpuFetchValid <= 1'b1;
        cpuFetchFirst <= f;
        cpuFetchAddr  <= a;
        @(posedge clk_sys);
        check({31'h00000000, cpuHalt}, {31'h00000000, e}, m);
        cpuFetchValid <= 1'b0;
        @(posedge clk_sys);
    endtask : fetch

    task automatic release_cpu();
        wr(OFS_CTRL, 32'h00000000);
        @(posedge clk_sys);
    endtask : release_cpu

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_strap();
        fetch(24'h000100, 1'b0, 1'b0, "strap later byte");
        fetch(24'h000100, 1'b1, 1'b1, "strap first fetch");
        fetch(24'h000101, 1'b1, 1'b1, "held while halted");
        rdchk(OFS_CTRL, 32'h00000080, "strap break-next");
        rdchk(OFS_STATUS, 32'h0000000F, "strap status");
        release_cpu();
        fetch(24'h000102, 1'b1, 1'b0, "strap released");
        $display("done strap");
    endtask : t_strap

    task automatic t_force();
        wr(OFS_CTRL, 32'h00000080);
        fetch(24'h000200, 1'b0, 1'b0, "forced later byte");
        fetch(24'h000201, 1'b1, 1'b1, "forced break");
        rdchk(OFS_CTRL, 32'h00000080, "forced bit kept");
        release_cpu();
        fetch(24'h000202, 1'b1, 1'b0, "forced released");
        $display("done force");
    endtask : t_force

    task automatic t_match();
        logic [23:0] a;
        logic [7:0]  en;
        logic [7:0]  oth;
        for (int i = 0; i < 4; i++)
        begin
            a   = {4'h4, 4'(i), 16'h12A7};
            en  = 8'(8 << i);
            oth = 8'(8 << ((i + 1) % 4));
            wr(OFS_MATCH0 + 8'(4 * i), {8'h00, a});
            wr(OFS_CTRL, {24'h000000, oth});
            fetch(a, 1'b1, 1'b0, "match disabled");
            wr(OFS_CTRL, {24'h000000, en});
            fetch(a, 1'b0, 1'b0, "match later byte");
            fetch(a ^ 24'h000001, 1'b1, 1'b0, "near miss");
            fetch(a, 1'b1, 1'b1, "match hit");
            rdchk(OFS_CTRL, {24'h000000, 8'h80 | en}, "match sets break-next");
            release_cpu();
        end
        $display("done match");
    endtask : t_match

    task automatic t_page();
        wr(OFS_CTRL, 32'h00000010);
        fetch(24'h411200, 1'b1, 1'b0, "full compare");
        wr(OFS_CTRL, 32'h00000014);
        fetch(24'h411300, 1'b1, 1'b0, "other page");
        fetch(24'h411200, 1'b1, 1'b1, "same page");
        release_cpu();
        $display("done page");
    endtask : t_page

    task automatic t_irq();
        wr(OFS_IRQ_STAT, 32'h00000007);
        rdchk(OFS_IRQ_STAT, 32'h00000000, "status cleared");
        wr(OFS_IRQ_MASK, 32'h00000004);
        u_host.frame(8'hA5);
        repeat (4) @(posedge clk_sys);
        check({31'h00000000, breakIrq}, 32'h00000001, "link irq");
        rdchk(OFS_IRQ_STAT, 32'h00000004, "link edge seen");
        wr(OFS_IRQ_MASK, 32'h00000000);
        @(posedge clk_sys);
        check({31'h00000000, breakIrq}, 32'h00000000, "masked");
        wr(OFS_IRQ_STAT, 32'h00000004);
        wr(OFS_IRQ_MASK, 32'h00000001);
        wr(OFS_CTRL, 32'h00000080);
        fetch(24'h000300, 1'b1, 1'b1, "break for irq");
        check({31'h00000000, breakIrq}, 32'h00000001, "break irq");
        release_cpu();
        wr(OFS_IRQ_STAT, 32'h00000001);
        @(posedge clk_sys);
        check({31'h00000000, breakIrq}, 32'h00000000, "irq cleared");
        wr(8'h20, 32'h000000FF);
        rdchk(8'h20, 32'h00000000, "unmapped");
        $display("done irq");
    endtask : t_irq

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        nErrors++;
        summarize();
    end

    initial
    begin
        rst_b         = 1'b0;
        hsel          = 1'b0;
        haddr         = '0;
        htrans        = 2'h0;
        hwrite        = 1'b0;
        hsize         = 3'h2;
        hwdata        = '0;
        cpuFetchValid = 1'b0;
        cpuFetchFirst = 1'b0;
        cpuFetchAddr  = '0;
        nErrors       = 0;
        nCompared     = 0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        u_host.release_strap();
        t_strap();
        t_force();
        t_match();
        t_page();
        t_irq();
        summarize();
    end
endmodule : dbc_break_ctrl_tb
